// *** shared/supply_monitor_defs.svh ***
// Register map, field positions, reset values and timing counts of the supply monitor.
// Assumes a 50 MHz core clock and a word-addressed AHB-Lite register window.
// Summary of operation
// - Bit 6 read-only live combined comparator status.
// - Fault flag bit 5 sets while status low.
// - Healthy timer of 256 ms starts when high.
// - Timer expiry clears the fault flag.
// - Software clear ignored while status low.
// - Flag raises interrupt; core vectors to 0043h.
// - Trip field bits 4:2 drive comparator references.
// - Bit 1 shows which rail caused fault.
// - Bit 0 enables monitor; comparators used only then.
// - Flag interrupts only when second enable bit set; sticky bits with mask set interrupt regardless.
// - Brief supply glitches are filtered out.
`ifndef SUPPLY_MONITOR_DEFS_SVH
`define SUPPLY_MONITOR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SM_ADDR_CONTROL 6'h00
`define SM_ADDR_IRQ_STATUS 6'h04
`define SM_ADDR_IRQ_MASK 6'h08
`define SM_ADDR_INT_ENABLE 6'h0c

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define SM_BIT_STATUS 6
`define SM_BIT_FLAG 5
`define SM_TRIP_HI 4
`define SM_TRIP_LO 2
`define SM_BIT_SOURCE 1
`define SM_BIT_ENABLE 0
`define SM_IE_BIT_MONITOR 1
`define SM_CONTROL_RESET 8'h00
`define SM_CONTROL_WMASK 8'h3d
`define SM_TRIP_MAX 3'h4
`define SM_VECTOR_ADDR 16'h0043

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SM_CLK_HZ 50000000
`define SM_HEALTHY_MS 256
`define SM_HEALTHY_CYCLES (`SM_CLK_HZ / 1000 * `SM_HEALTHY_MS)
`define SM_GLITCH_NS 1000
`define SM_GLITCH_CYCLES ((`SM_GLITCH_NS + 19) / 20)

`endif

// *** shared/supply_monitor_pkg.sv ***
// Types shared by the supply monitor files.
// Assumes nothing beyond the defs header.
package supply_monitor_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_FAULT = 3'b010,
        ST_HEALTHY = 3'b100
    } monitor_state_e;
    typedef logic [7:0] control_t;
endpackage : supply_monitor_pkg

// *** rtl/supply_glitch_filter.sv ***
// Per-rail synchroniser and glitch filter for the comparator outputs.
// Assumes asynchronous comparator levels and the shared clock enable.
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.svh"
module supply_glitch_filter (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [1:0] raw_in,
    output logic [1:0] clean_out
);
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_rail
            logic s1_reg;
            logic s2_reg;
            logic [5:0] cnt_reg;
            logic out_reg;
            wire logic differs = (s2_reg != out_reg);
            wire logic settled = (cnt_reg == 6'(`SM_GLITCH_CYCLES - 1));
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    s1_reg <= 1'b1;
                    s2_reg <= 1'b1;
                    cnt_reg <= 6'h00;
                    out_reg <= 1'b1;
                end else if (clk_en) begin
                    s1_reg <= raw_in[g];
                    s2_reg <= s1_reg;
                    // A level must persist before the monitor believes it.
                    cnt_reg <= (differs && !settled) ? cnt_reg + 6'h01 : 6'h00;
                    if (differs && settled) begin
                        out_reg <= s2_reg;
                    end
                end
            end
            assign clean_out[g] = out_reg;
        end
    endgenerate
endmodule : supply_glitch_filter
`default_nettype wire

// *** rtl/supply_monitor.sv ***
// Supply monitor control/status logic with an AHB-Lite register slave.
// Assumes comparator outputs high when the rail is above its trip point.
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.svh"
module supply_monitor
    import supply_monitor_pkg::*;
#(
    parameter int unsigned HEALTHY_CYCLES = `SM_HEALTHY_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic analog_cmp_ok,
    input wire logic digital_cmp_ok,
    output logic [2:0] trip_select,
    output logic comparators_on,
    output logic irq,
    output logic [15:0] irq_vector
);
    // ------------------------------------------------------------------------
    // Comparator inputs
    // ------------------------------------------------------------------------
    logic [1:0] cmp_clean;
    supply_glitch_filter u_filter (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .raw_in({analog_cmp_ok, digital_cmp_ok}),
        .clean_out(cmp_clean)
    );

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic enable_reg;
    logic [2:0] trip_reg;
    logic flag_reg;
    logic flag_next;
    logic source_reg;
    logic [1:0] sticky_reg;
    logic [1:0] mask_reg;
    logic ie_reg;
    logic [31:0] timer_reg;
    monitor_state_e state_reg;
    monitor_state_e state_next;
    logic wr_pend_reg;
    logic [5:0] wr_addr_reg;
    logic [31:0] hrdata_reg;

    wire logic analog_ok = cmp_clean[1];
    wire logic digital_ok = cmp_clean[0];
    wire logic both_ok = analog_ok & digital_ok;
    wire logic live_status = enable_reg ? both_ok : 1'b1;
    wire logic rail_low = enable_reg & ~both_ok;
    wire logic timer_done = (state_reg == ST_HEALTHY) && (timer_reg == HEALTHY_CYCLES - 1);

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire logic access = hsel & hready & htrans[1] & clk_en;
    wire logic rd_access = access & ~hwrite;
    wire logic wr_ctl = wr_pend_reg & (wr_addr_reg == `SM_ADDR_CONTROL);
    wire logic wr_sts = wr_pend_reg & (wr_addr_reg == `SM_ADDR_IRQ_STATUS);
    wire logic wr_msk = wr_pend_reg & (wr_addr_reg == `SM_ADDR_IRQ_MASK);
    wire logic wr_ie = wr_pend_reg & (wr_addr_reg == `SM_ADDR_INT_ENABLE);
    wire control_t control_view = {1'b0, live_status, flag_reg, trip_reg, source_reg,
                                   enable_reg};
    wire logic [5:0] rd_addr = haddr[5:0];
    wire logic [31:0] rd_value =
        (rd_addr == `SM_ADDR_CONTROL) ? {24'h000000, control_view} :
        (rd_addr == `SM_ADDR_IRQ_STATUS) ? {30'h00000000, sticky_reg} :
        (rd_addr == `SM_ADDR_IRQ_MASK) ? {30'h00000000, mask_reg} :
        (rd_addr == `SM_ADDR_INT_ENABLE) ? {30'h00000000, ie_reg, 1'b0} : 32'h00000000;
    wire logic [2:0] trip_wr = hwdata[`SM_TRIP_HI:`SM_TRIP_LO];
    wire logic trip_valid = (trip_wr <= `SM_TRIP_MAX);
    wire logic sw_flag_clear = wr_ctl & ~hwdata[`SM_BIT_FLAG];
    wire logic sw_flag_set = wr_ctl & hwdata[`SM_BIT_FLAG];
    wire logic flag_rise = flag_next & ~flag_reg;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 6'h00;
            hrdata_reg <= 32'h00000000;
        end else if (clk_en) begin
            wr_pend_reg <= access & hwrite;
            wr_addr_reg <= haddr[5:0];
            if (rd_access) begin
                hrdata_reg <= rd_value;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Healthy-supply sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (rail_low) begin
                    state_next = ST_FAULT;
                end
            end
            ST_FAULT: begin
                if (!enable_reg) begin
                    state_next = ST_OFF;
                end else if (both_ok) begin
                    state_next = ST_HEALTHY;
                end
            end
            ST_HEALTHY: begin
                if (rail_low) begin
                    state_next = ST_FAULT;
                end else if (timer_done || !enable_reg) begin
                    state_next = ST_OFF;
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    always_comb begin
        flag_next = flag_reg;
        if (sw_flag_set) begin
            flag_next = 1'b1;
        end
        if (sw_flag_clear && !rail_low) begin
            flag_next = 1'b0;
        end
        if (timer_done) begin
            flag_next = 1'b0;
        end
        if (rail_low) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_OFF;
            timer_reg <= 32'h00000000;
            flag_reg <= 1'b0;
            source_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            timer_reg <= (state_reg == ST_HEALTHY && !rail_low) ? timer_reg + 32'h1 :
                         32'h00000000;
            flag_reg <= flag_next;
            if (rail_low) begin
                source_reg <= ~analog_ok;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control, interrupt enable and sticky status
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_reg <= 1'b0;
            trip_reg <= 3'h0;
            mask_reg <= 2'h0;
            ie_reg <= 1'b0;
            sticky_reg <= 2'h0;
        end else if (clk_en) begin
            if (wr_ctl) begin
                enable_reg <= hwdata[`SM_BIT_ENABLE];
                if (trip_valid) begin
                    trip_reg <= trip_wr;
                end
            end
            if (wr_msk) begin
                mask_reg <= hwdata[1:0];
            end
            if (wr_ie) begin
                ie_reg <= hwdata[`SM_IE_BIT_MONITOR];
            end
            // Bit 0 latches a fault raise, bit 1 a timed release; set beats clear.
            sticky_reg <= (sticky_reg & ~(wr_sts ? hwdata[1:0] : 2'h0))
                          | {timer_done, flag_rise};
        end
    end

    assign trip_select = trip_reg;
    assign comparators_on = enable_reg;
    // The monitor flag gated by the enable bit, or any sticky bit whose mask bit is set, drives the core interrupt.
    assign irq = (flag_reg & ie_reg) | (|(sticky_reg & mask_reg));
    assign irq_vector = `SM_VECTOR_ADDR;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_flag_on_low: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && rail_low) |=> flag_reg)
        else $error("fault flag not set on low supply");
    a_status_live: assert property (@(posedge clk) disable iff (sys_rst)
        enable_reg |-> (control_view[`SM_BIT_STATUS] == (analog_ok & digital_ok)))
        else $error("status bit not live");
    a_release_time: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && timer_done && !rail_low) |=> !flag_reg)
        else $error("flag not cleared at expiry");
    a_no_sw_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && sw_flag_clear && rail_low) |=> flag_reg)
        else $error("software cleared flag during fault");
    a_timer_reset: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && rail_low) |=> (timer_reg == 32'h0))
        else $error("timer not reset on drop");
    a_timer_start: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && state_reg == ST_FAULT && enable_reg && both_ok) |=> state_reg == ST_HEALTHY)
        else $error("healthy timer did not start");
    a_irq_gate: assert property (@(posedge clk) disable iff (sys_rst)
        (flag_reg && !ie_reg && !(|(sticky_reg & mask_reg))) |-> !irq)
        else $error("interrupt without enable");
    a_disabled_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (!enable_reg && clk_en) |=> (state_reg != ST_HEALTHY || $past(state_reg) == ST_HEALTHY))
        else $error("monitor acted while disabled");
    a_source_dig: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && rail_low && analog_ok) |=> !source_reg)
        else $error("fault source wrong");
    a_trip_legal: assert property (@(posedge clk) disable iff (sys_rst)
        trip_reg <= `SM_TRIP_MAX)
        else $error("illegal trip select");
    c_fault: cover property (@(posedge clk) disable iff (sys_rst) flag_rise);
    c_release: cover property (@(posedge clk) disable iff (sys_rst) timer_done);
    c_redrop: cover property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_HEALTHY && rail_low);
    c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
endmodule : supply_monitor
`default_nettype wire

// *** sim/supply_rail_model.sv ***
// Behavioural model of the two supply rail comparators.
// Assumes the bench sets rail levels in millivolts; outputs are asynchronous levels.
// Powered-down comparators report low, so a disabled monitor must ignore them.
`timescale 1ns/1ps
`default_nettype none
module supply_rail_model (
    input wire logic [2:0] trip_select,
    input wire logic comparators_on,
    input wire logic signed [31:0] analog_mv,
    input wire logic signed [31:0] digital_mv,
    output logic analog_cmp_ok,
    output logic digital_cmp_ok
);
    int thr_mv;

    // Reference level picked by the trip code; unused codes fall back to the highest one.
    always_comb begin
        case (trip_select)
            3'h0: thr_mv = 4630;
            3'h1: thr_mv = 4370;
            3'h2: thr_mv = 3080;
            3'h3: thr_mv = 2930;
            3'h4: thr_mv = 2630;
            default: thr_mv = 4630;
        endcase
    end

    assign analog_cmp_ok = comparators_on && (analog_mv > thr_mv);
    assign digital_cmp_ok = comparators_on && (digital_mv > thr_mv);
endmodule : supply_rail_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the supply monitor through its AHB-Lite register window.
// Assumes zero-wait-state slave and a shortened healthy interval of 100 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defs.svh"
module tb_top;
    logic clk, sys_rst, clk_en, hsel, hwrite, hreadyout, hresp, comparators_on, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, trip_select;
    logic [15:0] irq_vector;
    logic analog_cmp_ok, digital_cmp_ok;
    int analog_mv, digital_mv, fail_count, n_compared;
    localparam logic [31:0] CTRL = 32'h00;
    localparam logic [31:0] STKY = 32'h04;
    localparam logic [31:0] MASK = 32'h08;
    localparam logic [31:0] IEN = 32'h0c;

    supply_monitor #(.HEALTHY_CYCLES(100)) dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .analog_cmp_ok(analog_cmp_ok), .digital_cmp_ok(digital_cmp_ok),
        .trip_select(trip_select), .comparators_on(comparators_on), .irq(irq),
        .irq_vector(irq_vector));
    supply_rail_model rails (.trip_select(trip_select), .comparators_on(comparators_on),
        .analog_mv(analog_mv), .digital_mv(digital_mv), .analog_cmp_ok(analog_cmp_ok),
        .digital_cmp_ok(digital_cmp_ok));

    // ------------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------------
    task automatic summarize();
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask : check

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                fail_count++;
                summarize();
            end
            @(posedge clk);
        end
    endtask : wait_rdy

    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : xfer

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string name);
        xfer(a, 1'b0, 32'h0);
        check(name, rd & m, e);
    endtask : rd_chk

    function automatic logic [31:0] ctl(input logic st, input logic fl, input logic [2:0] tr,
                                        input logic src, input logic en);
        return {25'h0, st, fl, tr, src, en};
    endfunction : ctl

    // ------------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        sys_rst = 1'b1; clk_en = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; analog_mv = 5000; digital_mv = 5000;
        fail_count = 0; n_compared = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check("vector", {16'h0, irq_vector}, 32'h0043);
        check("hresp", {31'h0, hresp}, 32'h0);
        rd_chk(CTRL, 32'hff, ctl(1, 0, 0, 0, 0), "control after reset");
        xfer(32'h10, 1'b1, 32'hffffffff);
        rd_chk(32'h10, 32'hffffffff, 32'h0, "unmapped");
        for (int c = 0; c < 5; c++) begin
            xfer(CTRL, 1'b1, ctl(0, 0, 3'(c), 0, 1));
            rd_chk(CTRL, 32'hff, ctl(1, 0, 3'(c), 0, 1), "trip field");
            check("trip port", {29'h0, trip_select}, 32'(c));
        end
        xfer(CTRL, 1'b1, ctl(0, 0, 3'h5, 0, 1));
        rd_chk(CTRL, 32'hff, ctl(1, 0, 3'h4, 0, 1), "bad trip code");
        xfer(CTRL, 1'b1, ctl(0, 0, 3'h1, 0, 1));
        check("comparators on", {31'h0, comparators_on}, 32'h1);
        digital_mv <= 4000;
        repeat (10) @(posedge clk);
        digital_mv <= 5000;
        repeat (70) @(posedge clk);
        rd_chk(CTRL, 32'hff, ctl(1, 0, 3'h1, 0, 1), "glitch");
        analog_mv <= 4000;
        repeat (60) @(posedge clk);
        rd_chk(CTRL, 32'hff, ctl(0, 1, 3'h1, 1, 1), "analog fault");
        check("irq gated", {31'h0, irq}, 32'h0);
        xfer(IEN, 1'b1, 32'h2);
        rd_chk(STKY, 32'hff, 32'h1, "sticky rise");
        check("irq enabled", {31'h0, irq}, 32'h1);
        xfer(CTRL, 1'b1, ctl(0, 0, 3'h1, 0, 1));
        rd_chk(CTRL, 32'h20, 32'h20, "clear refused");
        analog_mv <= 5000;
        repeat (80) @(posedge clk);
        analog_mv <= 4000;
        repeat (70) @(posedge clk);
        analog_mv <= 5000;
        repeat (130) @(posedge clk);
        rd_chk(CTRL, 32'h60, 32'h60, "timer restart");
        repeat (40) @(posedge clk);
        rd_chk(CTRL, 32'h60, 32'h40, "timed release");
        rd_chk(STKY, 32'hff, 32'h3, "sticky release");
        check("irq idle", {31'h0, irq}, 32'h0);
        xfer(MASK, 1'b1, 32'h2);
        rd_chk(MASK, 32'hff, 32'h2, "mask");
        check("irq masked in", {31'h0, irq}, 32'h1);
        xfer(STKY, 1'b1, 32'h3);
        rd_chk(STKY, 32'hff, 32'h0, "sticky w1c");
        check("irq cleared", {31'h0, irq}, 32'h0);
        digital_mv <= 4000;
        repeat (60) @(posedge clk);
        rd_chk(CTRL, 32'h62, 32'h20, "digital fault");
        xfer(CTRL, 1'b1, ctl(0, 0, 3'h1, 0, 0));
        rd_chk(CTRL, 32'hff, ctl(1, 1, 3'h1, 0, 0), "disabled");
        check("comparators off", {31'h0, comparators_on}, 32'h0);
        repeat (60) @(posedge clk);
        rd_chk(CTRL, 32'hff, ctl(1, 1, 3'h1, 0, 0), "off ignores rails");
        xfer(CTRL, 1'b1, ctl(0, 0, 3'h1, 0, 0));
        rd_chk(CTRL, 32'hff, ctl(1, 0, 3'h1, 0, 0), "clear while off");
        check("irq off", {31'h0, irq}, 32'h0);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
